/* File: rtl/fetch_pkg.sv */
// constants, types and decode helpers for the instruction fetch pipeline
package fetch_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 8;
   localparam int PHASES_PER_CYCLE = 4;

   // ----------------------------------------------------------------
   // program counter
   // ----------------------------------------------------------------
   localparam int             PC_W     = 21;
   localparam logic [20:0]    PC_RESET = 21'h00_0000;
   localparam logic [20:0]    PC_STEP  = 21'h00_0002;
   localparam logic [7:0]     W_RESET  = 8'h00;
   localparam logic [15:0]    WORD_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // opcode fields
   // ----------------------------------------------------------------
   localparam logic [3:0]  SECOND_WORD_TAG = 4'hF;
   localparam logic [7:0]  OPC_JUMP        = 8'hEF;
   localparam logic [6:0]  OPC_CALL        = 7'h76;
   localparam logic [9:0]  OPC_LOAD_FSEL   = 10'h3B8;
   localparam logic [3:0]  OPC_MOVE_FF     = 4'hC;
   localparam logic [4:0]  OPC_BRANCH      = 5'h1A;
   localparam logic [5:0]  OPC_ADD_WF      = 6'h09;
   localparam logic [6:0]  OPC_MOVE_WF     = 7'h37;
   localparam logic [6:0]  OPC_TEST_SKIP   = 7'h33;
   localparam logic [7:0]  OPC_MOVE_LW     = 8'h0E;
   localparam logic [7:0]  OPC_RET_LW      = 8'h0C;
   localparam logic [13:0] OPC_TABLE_RD    = 14'h0002;
   localparam logic [1:0]  TABLE_POST_INC  = 2'b01;

   // ----------------------------------------------------------------
   // data space addresses
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_PC_LOW      = 12'hFF9;
   localparam logic [11:0] ADDR_TBL_UPPER   = 12'hFF8;
   localparam logic [11:0] ADDR_TBL_HIGH    = 12'hFF7;
   localparam logic [11:0] ADDR_TBL_LOW     = 12'hFF6;
   localparam logic [11:0] ADDR_TBL_LATCH   = 12'hFF5;
   localparam logic [7:0]  ACCESS_SPLIT     = 8'h60;
   localparam logic [3:0]  ACCESS_SFR_BANK  = 4'hF;
   localparam logic [3:0]  ACCESS_GPR_BANK  = 4'h0;

   typedef enum logic [1:0] {
      PH_ONE   = 2'b00,
      PH_TWO   = 2'b01,
      PH_THREE = 2'b10,
      PH_FOUR  = 2'b11
   } phase_t;

   typedef enum logic [3:0] {
      OP_NOP    = 4'b0000,
      OP_JUMP   = 4'b0001,
      OP_CALL   = 4'b0010,
      OP_LFSEL  = 4'b0011,
      OP_FILE_TO_FILE_MOVE  = 4'b0100,
      OP_BRANCH = 4'b0101,
      OP_ADD_W_TO_FILE  = 4'b0110,
      OP_MOVWF  = 4'b0111,
      OP_TSTSK  = 4'b1000,
      OP_MOVLW  = 4'b1001,
      OP_RETURN_WITH_LITERAL  = 4'b1010,
      OP_TBLRD  = 4'b1011,
      OP_SECOND = 4'b1100
   } op_t;

   function automatic op_t decode_op(input logic [15:0] w);
      op_t o;
      o = OP_NOP;
      if (w[15:12] == SECOND_WORD_TAG)    o = OP_SECOND;
      else if (w[15:8] == OPC_JUMP)       o = OP_JUMP;
      else if (w[15:9] == OPC_CALL)       o = OP_CALL;
      else if (w[15:6] == OPC_LOAD_FSEL)  o = OP_LFSEL;
      else if (w[15:12] == OPC_MOVE_FF)   o = OP_FILE_TO_FILE_MOVE;
      else if (w[15:11] == OPC_BRANCH)    o = OP_BRANCH;
      else if (w[15:10] == OPC_ADD_WF)    o = OP_ADD_W_TO_FILE;
      else if (w[15:9] == OPC_MOVE_WF)    o = OP_MOVWF;
      else if (w[15:9] == OPC_TEST_SKIP)  o = OP_TSTSK;
      else if (w[15:8] == OPC_MOVE_LW)    o = OP_MOVLW;
      else if (w[15:8] == OPC_RET_LW)     o = OP_RETURN_WITH_LITERAL;
      else if (w[15:2] == OPC_TABLE_RD)   o = OP_TBLRD;
      return o;
   endfunction

   // access bank map only; a banked access always lands in bank 0
   function automatic logic [11:0] file_addr(input logic banked, input logic [7:0] f);
      logic [11:0] a;
      a = {ACCESS_GPR_BANK, f};
      if (!banked && f >= ACCESS_SPLIT) a = {ACCESS_SFR_BANK, f};
      return a;
   endfunction

endpackage

/* File: rtl/phase_generator.sv */
// divides the core clock into four non-overlapping phases
`timescale 1ns/1ps
module phase_generator
   import fetch_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_b,
   output fetch_pkg::phase_t     phase
);

   phase_t phase_q;
   phase_t phase_d;

   always_comb begin
      case (phase_q)
         PH_ONE:   phase_d = PH_TWO;
         PH_TWO:   phase_d = PH_THREE;
         PH_THREE: phase_d = PH_FOUR;
         PH_FOUR:  phase_d = PH_ONE;
         default:  phase_d = PH_ONE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_q <= PH_ONE;
      end else begin
         phase_q <= phase_d;
      end
   end

   assign phase = phase_q;

   phase_order_a: assert property (@(posedge clk) disable iff (!rst_b)
      phase_q == PH_ONE |=> phase_q == PH_TWO ##1 phase_q == PH_THREE ##1 phase_q == PH_FOUR ##1 phase_q == PH_ONE)
      else $error("phase sequence broken");

endmodule

/* File: rtl/table_unit.sv */
// table pointer and byte latch for reads of program memory as data
`timescale 1ns/1ps
module table_unit
   import fetch_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        wr_en,
   input  wire logic [11:0] wr_addr,
   input  wire logic [7:0]  wr_data,
   input  wire logic        rd_strobe,
   input  wire logic        post_inc,
   input  wire logic [7:0]  tbl_byte,
   output logic      [20:0] tbl_addr,
   output logic      [7:0]  table_latch
);

   logic [20:0] table_pointer_q;
   logic [20:0] table_pointer_d;
   logic [7:0]  latch_q;
   logic [7:0]  latch_d;

   always_comb begin
      table_pointer_d = table_pointer_q;
      latch_d         = latch_q;
      if (wr_en && wr_addr == ADDR_TBL_LOW)   table_pointer_d[7:0]   = wr_data;
      if (wr_en && wr_addr == ADDR_TBL_HIGH)  table_pointer_d[15:8]  = wr_data;
      if (wr_en && wr_addr == ADDR_TBL_UPPER) table_pointer_d[20:16] = wr_data[4:0];
      if (rd_strobe) begin
         latch_d = tbl_byte;
         if (post_inc) table_pointer_d = table_pointer_q + 21'h00_0001;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         table_pointer_q <= PC_RESET;
         latch_q         <= W_RESET;
      end else begin
         table_pointer_q <= table_pointer_d;
         latch_q         <= latch_d;
      end
   end

   // byte address straight out; the memory picks the byte lane
   assign tbl_addr    = table_pointer_q;
   assign table_latch = latch_q;

   table_byte_a: assert property (@(posedge clk) disable iff (!rst_b)
      rd_strobe |=> latch_q == $past(tbl_byte) && (table_pointer_q == $past(table_pointer_q) + 21'h00_0001) == $past(post_inc))
      else $error("table latch or pointer step wrong");

endmodule

/* File: rtl/fetch_pipeline.sv */
// two-stage fetch and execute pipeline of the core front end
`timescale 1ns/1ps
// How it works
// - input clock divided into four phases
// - pc steps at phase one, fetch at four
// - fetched word enters ir at phase one
// - operand read phase two, write phase four
// - fetch overlaps execute, one cycle each
// - pc change flushes fetched word, two cycles
// - byte addressed memory, words at even addresses
// - pc steps by two, bit zero zero
// - jump word address loads pc bits 20:1
// - branch offset counts words, not bytes
// - second word tagged 1111 plus twelve bits
// - paired second word supplies move destination only
// - lone second word acts as no_operation
// - adding w to pc low advances bytes
// - return_with_literal returns, loads working register
// - table pointer addresses byte into latch
module fetch_pipeline
   import fetch_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   output logic      [20:0] pm_addr,
   input  wire logic [15:0] pm_data,
   output logic      [11:0] dm_addr,
   output logic             dm_rd_en,
   input  wire logic [7:0]  dm_rdata,
   output logic             dm_wr_en,
   output logic      [7:0]  dm_wdata,
   output logic      [20:0] tbl_addr,
   input  wire logic [7:0]  tbl_byte,
   output logic      [7:0]  table_latch,
   output logic      [7:0]  working_register,
   output logic             phase_one,
   output logic             phase_two,
   output logic             phase_three,
   output logic             phase_four
);

   // ----------------------------------------------------------------
   // phases
   // ----------------------------------------------------------------
   phase_t phase;

   phase_generator u_phase (
      .clk   (clk),
      .rst_b (rst_b),
      .phase (phase)
   );

   assign phase_one   = (phase == PH_ONE);
   assign phase_two   = (phase == PH_TWO);
   assign phase_three = (phase == PH_THREE);
   assign phase_four  = (phase == PH_FOUR);

   // ----------------------------------------------------------------
   // pipeline state
   // ----------------------------------------------------------------
   logic [20:0] pc_q,          pc_d;
   logic [20:0] fetch_addr_q,  fetch_addr_d;
   logic [15:0] fetch_word_q,  fetch_word_d;
   logic        fetch_valid_q, fetch_valid_d;
   logic [15:0] ir_q,          ir_d;
   logic        ir_valid_q,    ir_valid_d;
   logic        pending_q,     pending_d;
   logic        skip_q,        skip_d;
   logic [7:0]  operand_q,     operand_d;
   logic [7:0]  w_q,           w_d;
   logic [20:0] ret_q,         ret_d;

   // ----------------------------------------------------------------
   // decode of the word in execute
   // ----------------------------------------------------------------
   op_t         op;
   logic        paired;
   logic        lone_second;
   logic [11:0] rd_addr;
   logic [11:0] wr_addr;
   logic [20:0] exec_base;
   logic [8:0]  add_sum;
   logic        to_pc_low;
   logic        jump;
   logic [20:0] target;
   logic [7:0]  read_value;
   logic        tbl_strobe;

   assign op          = ir_valid_q ? decode_op(ir_q) : OP_NOP;
   assign paired      = (op == OP_SECOND) && pending_q;
   assign lone_second = (op == OP_SECOND) && !pending_q;
   // pc already points past the fetched word, so step back once
   assign exec_base   = pc_q - PC_STEP;
   assign rd_addr     = (op == OP_FILE_TO_FILE_MOVE) ? ir_q[11:0] : file_addr(ir_q[8], ir_q[7:0]);
   assign wr_addr     = paired ? ir_q[11:0] : file_addr(ir_q[8], ir_q[7:0]);
   assign add_sum     = {1'b0, operand_q} + {1'b0, w_q};
   assign to_pc_low   = (op == OP_ADD_W_TO_FILE) && ir_q[9] && (rd_addr == ADDR_PC_LOW);

   // the pc low byte and the table latch are answered here, not by data memory
   always_comb begin
      if (rd_addr == ADDR_PC_LOW)         read_value = exec_base[7:0];
      else if (rd_addr == ADDR_TBL_LATCH) read_value = table_latch;
      else                                read_value = dm_rdata;
   end

   // ----------------------------------------------------------------
   // which first word left the pairing open
   // ----------------------------------------------------------------
   logic file_to_file_move_q, file_to_file_move_d;

   // ----------------------------------------------------------------
   // data memory strobes
   // ----------------------------------------------------------------
   always_comb begin
      dm_rd_en = phase_two && (op == OP_FILE_TO_FILE_MOVE || op == OP_ADD_W_TO_FILE || op == OP_TSTSK);
      dm_wr_en = 1'b0;
      dm_wdata = w_q;
      if (phase_four) begin
         case (op)
            OP_ADD_W_TO_FILE: begin
               dm_wr_en = ir_q[9] && !to_pc_low;
               dm_wdata = add_sum[7:0];
            end
            OP_MOVWF: begin
               dm_wr_en = 1'b1;
            end
            OP_SECOND: begin
               dm_wr_en = paired && file_to_file_move_q;
               dm_wdata = operand_q;
            end
            default: begin
               dm_wr_en = 1'b0;
            end
         endcase
      end
      dm_addr = phase_four ? wr_addr : rd_addr;
   end

   // ----------------------------------------------------------------
   // execute effects and program counter change
   // ----------------------------------------------------------------
   always_comb begin
      jump   = 1'b0;
      target = pc_q;
      w_d    = w_q;
      ret_d  = ret_q;
      skip_d = skip_q;
      if (phase_one) skip_d = 1'b0;
      pending_d = pending_q;
      file_to_file_move_d   = file_to_file_move_q;
      if (phase_four) begin
         pending_d = 1'b0;
         case (op)
            OP_JUMP: begin
               // second word arrives on this very edge, so no extra cycle
               jump   = 1'b1;
               target = {pm_data[11:0], ir_q[7:0], 1'b0};
            end
            OP_CALL: begin
               jump   = 1'b1;
               target = {pm_data[11:0], ir_q[7:0], 1'b0};
               ret_d  = pc_q;
            end
            OP_FILE_TO_FILE_MOVE, OP_LFSEL: begin
               pending_d = 1'b1;
               file_to_file_move_d   = (op == OP_FILE_TO_FILE_MOVE);
            end
            OP_BRANCH: begin
               jump   = 1'b1;
               target = exec_base + {{9{ir_q[10]}}, ir_q[10:0], 1'b0};
            end
            OP_ADD_W_TO_FILE: begin
               if (to_pc_low) begin
                  jump   = 1'b1;
                  target = (exec_base + {13'h0000, w_q}) & ~21'h00_0001;
               end else if (!ir_q[9]) begin
                  w_d = add_sum[7:0];
               end
            end
            OP_TSTSK: begin
               skip_d = (operand_q == 8'h00);
            end
            OP_MOVLW: begin
               w_d = ir_q[7:0];
            end
            OP_RETURN_WITH_LITERAL: begin
               jump   = 1'b1;
               target = ret_q;
               w_d    = ir_q[7:0];
            end
            default: begin
               jump = 1'b0; // lone second word falls here as no_operation
            end
         endcase
      end
   end

   assign tbl_strobe = phase_four && (op == OP_TBLRD);

   // ----------------------------------------------------------------
   // pipeline registers
   // ----------------------------------------------------------------
   always_comb begin
      pc_d          = pc_q;
      fetch_addr_d  = fetch_addr_q;
      fetch_word_d  = fetch_word_q;
      fetch_valid_d = fetch_valid_q;
      ir_d          = ir_q;
      ir_valid_d    = ir_valid_q;
      operand_d     = operand_q;
      case (phase)
         PH_ONE: begin
            fetch_addr_d = pc_q;
            pc_d         = pc_q + PC_STEP;
            ir_d         = fetch_word_q;
            ir_valid_d   = fetch_valid_q && !skip_q;
         end
         PH_TWO: begin
            if (dm_rd_en) operand_d = read_value;
         end
         PH_FOUR: begin
            fetch_word_d  = pm_data;
            fetch_valid_d = !jump;
            if (jump) pc_d = target;
         end
         default: begin
            operand_d = operand_q;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_q          <= PC_RESET;
         fetch_addr_q  <= PC_RESET;
         fetch_word_q  <= WORD_RESET;
         fetch_valid_q <= 1'b0;
         ir_q          <= WORD_RESET;
         ir_valid_q    <= 1'b0;
         pending_q     <= 1'b0;
         file_to_file_move_q       <= 1'b0;
         skip_q        <= 1'b0;
         operand_q     <= W_RESET;
         w_q           <= W_RESET;
         ret_q         <= PC_RESET;
      end else begin
         pc_q          <= pc_d;
         fetch_addr_q  <= fetch_addr_d;
         fetch_word_q  <= fetch_word_d;
         fetch_valid_q <= fetch_valid_d;
         ir_q          <= ir_d;
         ir_valid_q    <= ir_valid_d;
         pending_q     <= pending_d;
         file_to_file_move_q       <= file_to_file_move_d;
         skip_q        <= skip_d;
         operand_q     <= operand_d;
         w_q           <= w_d;
         ret_q         <= ret_d;
      end
   end

   assign pm_addr          = fetch_addr_q;
   assign working_register = w_q;

   // ----------------------------------------------------------------
   // table reads
   // ----------------------------------------------------------------
   table_unit u_table (
      .clk         (clk),
      .rst_b       (rst_b),
      .wr_en       (dm_wr_en),
      .wr_addr     (dm_addr),
      .wr_data     (dm_wdata),
      .rd_strobe   (tbl_strobe),
      .post_inc    (ir_q[1:0] == TABLE_POST_INC),
      .tbl_byte    (tbl_byte),
      .tbl_addr    (tbl_addr),
      .table_latch (table_latch)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   pc_step_a: assert property (@(posedge clk) disable iff (!rst_b)
      phase_one |=> pc_q == $past(pc_q) + PC_STEP && pm_addr == $past(pc_q))
      else $error("pc did not step by two at phase one");

   pc_even_a: assert property (@(posedge clk) disable iff (!rst_b)
      pc_q[0] == 1'b0 && pm_addr[0] == 1'b0)
      else $error("pc bit zero set");

   fetch_capture_a: assert property (@(posedge clk) disable iff (!rst_b)
      phase_four && !jump |=> fetch_valid_q && fetch_word_q == $past(pm_data))
      else $error("fetched word not captured at phase four");

   ir_load_a: assert property (@(posedge clk) disable iff (!rst_b)
      phase_one |=> ir_q == $past(fetch_word_q) ##2 phase_four && ir_q == $past(ir_q, 2))
      else $error("instruction register not loaded at phase one");

   dm_phase_a: assert property (@(posedge clk) disable iff (!rst_b)
      (dm_rd_en |-> phase_two) and (dm_wr_en |-> phase_four))
      else $error("data memory strobe in wrong phase");

   flush_a: assert property (@(posedge clk) disable iff (!rst_b)
      jump |=> !fetch_valid_q && pc_q == $past(target) ##1 !ir_valid_q)
      else $error("branch did not flush the fetched word");

   jump_target_a: assert property (@(posedge clk) disable iff (!rst_b)
      phase_four && op == OP_JUMP |=> pc_q == {$past(pm_data[11:0]), $past(ir_q[7:0]), 1'b0})
      else $error("absolute jump target wrong");

   lone_nop_a: assert property (@(posedge clk) disable iff (!rst_b)
      phase_four && lone_second |-> !dm_wr_en && !jump && w_d == w_q)
      else $error("lone second word had an effect");

   return_with_literal_a: assert property (@(posedge clk) disable iff (!rst_b)
      phase_four && op == OP_RETURN_WITH_LITERAL |=> w_q == $past(ir_q[7:0]) && pc_q == $past(ret_q))
      else $error("return with literal wrong");

   jump_c:   cover property (@(posedge clk) disable iff (!rst_b) phase_four && op == OP_JUMP);
   paired_c: cover property (@(posedge clk) disable iff (!rst_b) phase_four && paired && dm_wr_en);
   lone_c:   cover property (@(posedge clk) disable iff (!rst_b) phase_four && lone_second);
   table_c:  cover property (@(posedge clk) disable iff (!rst_b) tbl_strobe);

endmodule

/* File: test/program_memory_model.sv */
// program and data memory model facing the fetch pipeline
`timescale 1ns/1ps
module program_memory_model (
   input  wire logic        clk,
   input  wire logic [7:0]  lit,
   input  wire logic [20:0] pm_addr,
   output logic      [15:0] pm_data,
   input  wire logic [11:0] dm_addr,
   input  wire logic        dm_rd_en,
   output logic      [7:0]  dm_rdata,
   input  wire logic        dm_wr_en,
   input  wire logic [7:0]  dm_wdata,
   input  wire logic [20:0] tbl_addr,
   output logic      [7:0]  tbl_byte
);
   logic [7:0] mem [0:4095];
   logic       tog;
   initial begin
      tog = 1'b0;
      for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
   end
   // idle read bus toggles so a stale sample never matches by luck
   always @(posedge clk) begin
      tog <= ~tog;
      if (dm_wr_en === 1'b1) mem[dm_addr] <= dm_wdata;
   end
   assign dm_rdata = (dm_rd_en === 1'b1) ? mem[dm_addr] : {8{tog}};
   assign tbl_byte = tbl_addr[7:0] ^ 8'hA5;
   // ----------------------------------------------------------------
   // program image, one word per even byte address
   // ----------------------------------------------------------------
   always_comb begin
      case (pm_addr[7:0])
         8'h00: pm_data = {8'h0E, lit};
         8'h02: pm_data = 16'h6E10;
         8'h04: pm_data = 16'h0E04;
         8'h06: pm_data = 16'hEC10;
         8'h08: pm_data = 16'hF000;
         8'h0A: pm_data = 16'h6E11;
         8'h0C: pm_data = 16'hEF18;
         8'h0E: pm_data = 16'hF000;
         8'h10: pm_data = 16'h0E77;
         8'h20: pm_data = 16'h26F9;
         8'h22: pm_data = 16'h0C11;
         8'h24: pm_data = 16'h0C22;
         8'h26: pm_data = 16'h0C5A;
         8'h30: pm_data = 16'h6612;
         8'h32: pm_data = 16'hC010;
         8'h34: pm_data = 16'hF013;
         8'h36: pm_data = 16'hC010;
         8'h38: pm_data = 16'hF014;
         8'h3A: pm_data = 16'h0E40;
         8'h3C: pm_data = 16'h6EF6;
         8'h3E: pm_data = 16'h0009;
         8'h40: pm_data = 16'h0009;
         8'h42: pm_data = 16'hCFF5;
         8'h44: pm_data = 16'hF016;
         8'h46: pm_data = 16'hD002;
         8'h48: pm_data = 16'h0E99;
         8'h4A: pm_data = 16'h6E17;
         8'h4C: pm_data = 16'h6E18;
         8'h4E: pm_data = 16'hEE00;
         8'h50: pm_data = 16'hF000;
         8'h52: pm_data = 16'hEF29;
         8'h54: pm_data = 16'hF000;
         default: pm_data = 16'h0000;
      endcase
   end
endmodule

/* File: test/fetch_pipeline_bench.sv */
// self-checking bench for the fetch pipeline
`timescale 1ns/1ps
module fetch_pipeline_bench;
   import fetch_pkg::*;
   logic        clk, rst_b, dm_rd_en, dm_wr_en, mon_on;
   logic        phase_one, phase_two, phase_three, phase_four;
   logic [20:0] pm_addr, tbl_addr;
   logic [15:0] pm_data;
   logic [11:0] dm_addr;
   logic [7:0]  dm_rdata, dm_wdata, tbl_byte, table_latch, working_register, lit;
   logic [3:0]  exp_ph;
   logic [19:0] exp_q [$];
   int          n_fail, comparisons, seed;

   fetch_pipeline i_fetch_pipeline (.clk(clk), .rst_b(rst_b), .pm_addr(pm_addr), .pm_data(pm_data),
      .dm_addr(dm_addr), .dm_rd_en(dm_rd_en), .dm_rdata(dm_rdata), .dm_wr_en(dm_wr_en),
      .dm_wdata(dm_wdata), .tbl_addr(tbl_addr), .tbl_byte(tbl_byte), .table_latch(table_latch),
      .working_register(working_register), .phase_one(phase_one), .phase_two(phase_two),
      .phase_three(phase_three), .phase_four(phase_four));
   program_memory_model i_program_memory_model (.clk(clk), .lit(lit), .pm_addr(pm_addr),
      .pm_data(pm_data), .dm_addr(dm_addr), .dm_rd_en(dm_rd_en), .dm_rdata(dm_rdata),
      .dm_wr_en(dm_wr_en), .dm_wdata(dm_wdata), .tbl_addr(tbl_addr), .tbl_byte(tbl_byte));

   initial clk = 1'b0;
   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // output watcher: phases, alignment, strobes, queued writes
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (mon_on) begin
         check({28'h0, phase_four, phase_three, phase_two, phase_one}, {28'h0, exp_ph});
         check({31'h0, pm_addr[0]}, 32'h0);
         if (dm_rd_en === 1'b1) check({31'h0, phase_two}, 32'h1);
         if (dm_wr_en === 1'b1) begin
            check({31'h0, phase_four}, 32'h1);
            // pointer loads land in the special area and are judged by their effect
            if (dm_addr[11:8] !== 4'hF) begin
               if (exp_q.size() == 0) check({20'h0, dm_addr}, 32'hFFFF_FFFF);
               else check({12'h0, dm_addr, dm_wdata}, {12'h0, exp_q.pop_front()});
            end
         end
         exp_ph <= {exp_ph[2:0], exp_ph[3]};
      end
   end

   // ----------------------------------------------------------------
   // one pass of the program image, entered through reset
   // ----------------------------------------------------------------
   task automatic run_program(input logic [7:0] l);
      @(posedge clk);
      #1 rst_b = 1'b0;
      mon_on = 1'b0;
      lit = l;
      exp_q.delete();
      exp_q.push_back({12'h010, l});
      exp_q.push_back({12'h011, 8'h5A});
      exp_q.push_back({12'h014, l});
      exp_q.push_back({12'h016, 8'h41 ^ 8'hA5});
      exp_q.push_back({12'h018, 8'h40});
      repeat (10) @(posedge clk);
      check({28'h0, phase_four, phase_three, phase_two, phase_one}, 32'h1);
      check({11'h0, pm_addr}, 32'h0);
      check({24'h0, working_register}, 32'h0);
      #1 rst_b = 1'b1;
      exp_ph = 4'b0001;
      mon_on = 1'b1;
      repeat (4) begin
         @(posedge clk);
         check({30'h0, dm_rd_en, dm_wr_en}, 32'h0);
      end
      for (int c = 0; c < 400 && exp_q.size() > 0; c++) @(posedge clk);
      repeat (8) @(posedge clk);
      check(exp_q.size(), 32'h0);
      check({24'h0, working_register}, 32'h40);
      check({11'h0, tbl_addr}, 32'h42);
      check({24'h0, table_latch}, {24'h0, 8'h41 ^ 8'hA5});
   endtask

   initial begin
      seed = 32'h085b_5a98;
      rst_b = 1'b0;
      lit = 8'h00;
      mon_on = 1'b0;
      exp_ph = 4'b0001;
      n_fail = 0;
      comparisons = 0;
      // second pass resets while the idle loop runs
      for (int k = 0; k < 2; k++) begin
         run_program(8'($random(seed)));
         $display("program pass %0d done", k);
      end
      conclude();
   end

   initial begin
      #(CLK_PERIOD_NS * 4000);
      n_fail++;
      $display("watchdog expired");
      conclude();
   end
endmodule
